// [hdl/hbu_top.sv]
// Hardware breakpoint unit with APB register slave
`timescale 1ns/100ps
module hbu_top
    import hbu_pkg::*;
(
    input logic pclk, // Clock, also bus clock
    input logic presetn, // Async reset, active low
    input logic psel, // APB select
    input logic penable, // APB enable
    input logic pwrite, // APB direction
    input logic [7:0] paddr, // APB byte address
    input logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input logic ifetch_valid, // Instruction fetch strobe
    input logic [31:0] ifetch_vaddr, // Fetch virtual address
    input logic dacc_valid, // Data access strobe
    input logic dacc_write, // Access is a store
    input logic dacc_fpu_store, // Access is FPU store word
    input logic [31:0] dacc_vaddr, // Data virtual address
    input logic [31:0] dacc_wdata, // Store data
    input logic late_valid, // Late load or FPU data strobe
    input logic [31:0] late_data, // Late data value
    input logic [1:0] cpu_mode, // Operating mode
    input logic cpu_exl, // First exception level
    input logic cpu_erl, // Second exception level
    output logic bp_exc_req, // Breakpoint exception pulse
    output logic probe_trigger_out, // Probe trigger
    output logic irq // Interrupt level
);
    logic [31:0] breakpoint_control_reg_r;
    logic [31:0] iaddr_r;
    logic [31:0] iaddr_mask_r;
    logic [31:0] daddr_r;
    logic [31:0] daddr_mask_r;
    logic [31:0] dval_r;
    logic [31:0] dval_mask_r;
    logic [IRQ_NUM-1:0] irq_stat_r;
    logic [IRQ_NUM-1:0] irq_stat_nxt;
    logic [IRQ_NUM-1:0] irq_en_r;
    logic [IRQ_NUM-1:0] irq_en_nxt;
    logic irq_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic bp_exc_req_r;
    logic probe_trigger_out_r;
    logic [2:0] probe_trigger_out_cnt_r;
    hbu_lv_state_type lv_state_r;
    logic lv_write_r;
    logic [31:0] cmp_ref [CMP_NUM];
    logic [31:0] cmp_mask [CMP_NUM];
    logic [31:0] cmp_probe [CMP_NUM];
    logic [CMP_NUM-1:0] cmp_hit;
    logic wr_en;
    logic instr_addr_bp_enable;
    logic data_read_bp_enable;
    logic data_write_bp_enable;
    logic data_value_bp_enable;
    logic imode_ok;
    logic dmode_ok;
    logic dir_ok;
    logic ev_instr;
    logic ev_data_now;
    logic ev_data_late;
    logic ev_data;
    logic ev_dwrite;
    logic ev_dread;
    logic lv_start;
    logic exc_cond;
    logic probe_trigger_out_cond;

    // Decode of the mode enable nibble against the current mode
    function automatic logic mode_enabled(input logic [3:0] en, input logic [1:0] mode, input logic exl,
                                          input logic erl);
        logic ok;
        ok = 1'b0;
        if (exl || erl) begin
            ok = en[MODE_X];
        end else begin
            case (mode)
                HBU_USER: ok = en[MODE_U];
                HBU_SUPER: ok = en[MODE_S];
                HBU_KERNEL: ok = en[MODE_K];
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    // Write strobe at the completing access phase
    assign wr_en = psel && penable && pready_r && pwrite; // [RL13]

    // Control field aliases
    assign instr_addr_bp_enable = breakpoint_control_reg_r[BIT_IADDR_EN]; // [RL14]
    assign data_read_bp_enable = breakpoint_control_reg_r[BIT_DREAD_EN]; // [RL14]
    assign data_write_bp_enable = breakpoint_control_reg_r[BIT_DWRITE_EN]; // [RL14]
    assign data_value_bp_enable = breakpoint_control_reg_r[BIT_DVAL_EN];

    // Comparator operands; address slots fed with untranslated virtual addresses, value slots with store and late data
    assign cmp_ref[CMP_IADDR] = iaddr_r;
    assign cmp_mask[CMP_IADDR] = iaddr_mask_r;
    assign cmp_probe[CMP_IADDR] = ifetch_vaddr; // [RL3]
    assign cmp_ref[CMP_DADDR] = daddr_r;
    assign cmp_mask[CMP_DADDR] = daddr_mask_r;
    assign cmp_probe[CMP_DADDR] = dacc_vaddr; // [RL3]
    assign cmp_ref[CMP_SVAL] = dval_r;
    assign cmp_mask[CMP_SVAL] = dval_mask_r;
    assign cmp_probe[CMP_SVAL] = dacc_wdata;
    assign cmp_ref[CMP_LVAL] = dval_r;
    assign cmp_mask[CMP_LVAL] = dval_mask_r;
    assign cmp_probe[CMP_LVAL] = late_data;

    // One masked comparator per slot
    genvar g;
    generate
        for (g = 0; g < CMP_NUM; g++) begin : g_cmp
            hbu_cmp_if cif ();
            assign cif.ref_val = cmp_ref[g];
            assign cif.mask_val = cmp_mask[g];
            assign cif.probe_val = cmp_probe[g];
            assign cmp_hit[g] = cif.hit;
            hbu_match u_match (
                .port(cif)
            );
        end
    endgenerate

    // Mode qualification for each event class
    assign imode_ok = mode_enabled(breakpoint_control_reg_r[FLD_IMODE_HI:FLD_IMODE_LO], cpu_mode, cpu_exl,
                                   cpu_erl); // [RL5]
    assign dmode_ok = mode_enabled(breakpoint_control_reg_r[FLD_DMODE_HI:FLD_DMODE_LO], cpu_mode, cpu_exl,
                                   cpu_erl); // [RL5]

    // Instruction address event
    assign ev_instr = ifetch_valid && instr_addr_bp_enable && imode_ok && cmp_hit[CMP_IADDR]; // [RL1]

    // Data address event, direction qualified; value alone never fires
    assign dir_ok = dacc_write ? data_write_bp_enable : data_read_bp_enable; // [RL17]
    assign ev_data_now = dacc_valid && dir_ok && dmode_ok && cmp_hit[CMP_DADDR] &&
                         (!data_value_bp_enable ||
                          (dacc_write && !dacc_fpu_store && cmp_hit[CMP_SVAL])); // [RL2]
    // Loads and FPU stores compare their value once the data arrives
    assign lv_start = dacc_valid && dir_ok && dmode_ok && cmp_hit[CMP_DADDR] && data_value_bp_enable &&
                      (!dacc_write || dacc_fpu_store); // [RL11] [RL12]
    assign ev_data_late = (lv_state_r == HBU_LV_WAIT) && late_valid && cmp_hit[CMP_LVAL]; // [RL11] [RL12]
    assign ev_data = ev_data_now || ev_data_late; // [RL2]
    assign ev_dwrite = (ev_data_now && dacc_write) || (ev_data_late && lv_write_r);
    assign ev_dread = (ev_data_now && !dacc_write) || (ev_data_late && !lv_write_r);

    // Exception request, separate enables, masked in level two
    assign exc_cond = ((ev_instr && breakpoint_control_reg_r[BIT_IEXC]) ||
                       (ev_data && breakpoint_control_reg_r[BIT_DEXC])) && !cpu_erl; // [RL4] [RL9] [RL10]
    assign probe_trigger_out_cond = (ev_instr || ev_data) && breakpoint_control_reg_r[BIT_PROBE_EN]; // [RL6]

    // Late value compare tracker; newest access replaces an older one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_state_r <= HBU_LV_IDLE;
            lv_write_r <= 1'b0;
        end else begin
            case (lv_state_r)
                HBU_LV_IDLE: begin
                    if (lv_start) begin
                        lv_state_r <= HBU_LV_WAIT;
                        lv_write_r <= dacc_write;
                    end
                end
                HBU_LV_WAIT: begin
                    if (lv_start) begin
                        lv_write_r <= dacc_write;
                    end else if (late_valid) begin
                        lv_state_r <= HBU_LV_IDLE;
                    end
                end
                default: lv_state_r <= HBU_LV_IDLE;
            endcase
        end
    end

    // Control register; hardware status set wins over software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            breakpoint_control_reg_r <= CTRL_RESET; // [RL14]
        end else begin
            if (wr_en && paddr == OFS_CTRL) begin
                breakpoint_control_reg_r <= pwdata & CTRL_WMASK;
            end
            if (ev_instr) begin
                breakpoint_control_reg_r[BIT_ST_IA] <= 1'b1; // [RL15]
            end
            if (ev_dread) begin
                breakpoint_control_reg_r[BIT_ST_DR] <= 1'b1; // [RL15]
            end
            if (ev_dwrite) begin
                breakpoint_control_reg_r[BIT_ST_DW] <= 1'b1; // [RL15]
            end
        end
    end

    // Reference and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iaddr_r <= REF_RESET;
            iaddr_mask_r <= MASK_RESET;
            daddr_r <= REF_RESET;
            daddr_mask_r <= MASK_RESET;
            dval_r <= REF_RESET;
            dval_mask_r <= MASK_RESET;
        end else if (wr_en) begin
            case (paddr)
                OFS_IADDR: iaddr_r <= pwdata; // [RL13]
                OFS_IADDR_MASK: iaddr_mask_r <= pwdata;
                OFS_DADDR: daddr_r <= pwdata;
                OFS_DADDR_MASK: daddr_mask_r <= pwdata;
                OFS_DVAL: dval_r <= pwdata;
                OFS_DVAL_MASK: dval_mask_r <= pwdata;
                default: ;
            endcase
        end
    end

    // Interrupt status and enable next values
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        irq_en_nxt = irq_en_r;
        if (wr_en && paddr == OFS_IRQ_CLR) begin
            irq_stat_nxt = irq_stat_r & ~pwdata[IRQ_NUM-1:0];
        end
        if (wr_en && paddr == OFS_IRQ_EN) begin
            irq_en_nxt = pwdata[IRQ_NUM-1:0];
        end
        irq_stat_nxt[IRQ_INSTR] = irq_stat_nxt[IRQ_INSTR] | ev_instr;
        irq_stat_nxt[IRQ_DATA] = irq_stat_nxt[IRQ_DATA] | ev_data;
    end

    // Interrupt registers and level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
            irq_en_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            irq_r <= |(irq_stat_nxt & irq_en_nxt);
        end
    end

    // APB answer: one access cycle, read data latched in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= psel && !penable;
            pslverr_r <= 1'b0;
            if (psel && !penable) begin
                prdata_r <= 32'h00000000;
                case (paddr)
                    OFS_CTRL: prdata_r <= breakpoint_control_reg_r;
                    OFS_IADDR: prdata_r <= iaddr_r;
                    OFS_IADDR_MASK: prdata_r <= iaddr_mask_r;
                    OFS_DADDR: prdata_r <= daddr_r;
                    OFS_DADDR_MASK: prdata_r <= daddr_mask_r;
                    OFS_DVAL: prdata_r <= dval_r;
                    OFS_DVAL_MASK: prdata_r <= dval_mask_r;
                    OFS_IRQ_STAT: prdata_r <= {30'h0, irq_stat_r};
                    OFS_IRQ_CLR: prdata_r <= 32'h00000000;
                    OFS_IRQ_EN: prdata_r <= {30'h0, irq_en_r};
                    default: pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    // Exception pulse and two-cycle probe trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bp_exc_req_r <= 1'b0;
            probe_trigger_out_r <= 1'b0;
            probe_trigger_out_cnt_r <= 3'h0;
        end else begin
            bp_exc_req_r <= exc_cond; // [RL8]
            if (probe_trigger_out_cond) begin
                probe_trigger_out_r <= 1'b1; // [RL6]
                probe_trigger_out_cnt_r <= PROBE_TRIGGER_OUT_LOAD; // [RL7]
            end else if (probe_trigger_out_cnt_r != 3'h0) begin
                probe_trigger_out_cnt_r <= probe_trigger_out_cnt_r - 3'h1;
            end else begin
                probe_trigger_out_r <= 1'b0;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign bp_exc_req = bp_exc_req_r;
    assign probe_trigger_out = probe_trigger_out_r;
    assign irq = irq_r;

    // Checks
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_quiet;
        !probe_trigger_out_cond [*2];
    endsequence

    AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup ##1 s_access |-> pready) else $error("access phase not answered"); // [RL13]
    AST_PROBE_TRIGGER_OUT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        probe_trigger_out_cond |=> probe_trigger_out [*2]) else $error("trigger not held two cycles"); // [RL7]
    AST_PROBE_TRIGGER_OUT_DROP: assert property (@(posedge pclk) disable iff (!presetn)
        s_quiet |=> !probe_trigger_out) else $error("trigger stuck high"); // [RL7]
    AST_EXC_L2_MASK: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_erl |=> !bp_exc_req) else $error("exception raised in level two"); // [RL9]
    AST_IEXC: assert property (@(posedge pclk) disable iff (!presetn)
        ev_instr && breakpoint_control_reg_r[BIT_IEXC] && !cpu_erl |=> bp_exc_req)
        else $error("instruction match raised no exception"); // [RL8]
    AST_DEXC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !ev_instr && !breakpoint_control_reg_r[BIT_DEXC] |=> !bp_exc_req)
        else $error("data exception while disabled"); // [RL4]
    AST_ST_IA: assert property (@(posedge pclk) disable iff (!presetn)
        ev_instr |=> breakpoint_control_reg_r[BIT_ST_IA]) else $error("instruction status not set"); // [RL15]
    AST_VALUE_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        !data_read_bp_enable && !data_write_bp_enable |-> !ev_data)
        else $error("value compare alone fired"); // [RL17]
    AST_LATE_HIT: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(lv_state_r == HBU_LV_WAIT) ##1 (lv_state_r == HBU_LV_WAIT && late_valid && cmp_hit[CMP_LVAL])
        |=> irq_stat_r[IRQ_DATA]) else $error("late value match lost"); // [RL11]
    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        ev_instr && irq_en_r[IRQ_INSTR] && !wr_en |=> irq) else $error("interrupt level wrong");
endmodule

// [hdl/hbu_pkg.sv]
// Constants, register map and field layout of the hardware breakpoint unit
// Function
// [RL1] Instruction address compared to reference under mask
// [RL2] Data address, optional value, read/write qualified
// [RL3] All address comparisons use virtual addresses
// [RL4] Separate exception enables for instruction, data
// [RL5] Events enabled per mode and exception level
// [RL6] Probe trigger output in step with event
// [RL7] Trigger held exactly two bus clock cycles
// [RL8] Match raises level-two breakpoint exception request
// [RL9] Exception masked only in level-two mode
// [RL10] Exception generation steered by control register
// [RL11] Load value breakpoints reported late, imprecise
// [RL12] FPU store value breakpoints reported late
// [RL13] Seven breakpoint registers, software move access only
// [RL14] Bits 31,30,29 enable instr/read/write, reset off
// [RL15] Status bits [2:0] record breakpoint event kind
// [RL16] Mask bit one excludes bit from compare
// [RL17] Value compare alone never produces an event
package hbu_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IADDR = 8'h04;
    localparam logic [7:0] OFS_IADDR_MASK = 8'h08;
    localparam logic [7:0] OFS_DADDR = 8'h0C;
    localparam logic [7:0] OFS_DADDR_MASK = 8'h10;
    localparam logic [7:0] OFS_DVAL = 8'h14;
    localparam logic [7:0] OFS_DVAL_MASK = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN = 8'h24;
    // Control register fields
    localparam int BIT_IADDR_EN = 31;
    localparam int BIT_DREAD_EN = 30;
    localparam int BIT_DWRITE_EN = 29;
    localparam int BIT_DVAL_EN = 28;
    localparam int FLD_IMODE_HI = 26;
    localparam int FLD_IMODE_LO = 23;
    localparam int FLD_DMODE_HI = 21;
    localparam int FLD_DMODE_LO = 18;
    localparam int BIT_IEXC = 17;
    localparam int BIT_DEXC = 16;
    localparam int BIT_PROBE_EN = 15;
    localparam int BIT_ST_DW = 2;
    localparam int BIT_ST_DR = 1;
    localparam int BIT_ST_IA = 0;
    // Writable bits of the control register; reserved bits other than bit 22 read zero
    localparam logic [31:0] CTRL_WMASK = 32'hF7FF8007;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] REF_RESET = 32'h00000000;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    // Mode enable nibble positions: user, supervisor, kernel, exception level
    localparam int MODE_U = 3;
    localparam int MODE_S = 2;
    localparam int MODE_K = 1;
    localparam int MODE_X = 0;
    // Interrupt status bits
    localparam int IRQ_NUM = 2;
    localparam int IRQ_INSTR = 0;
    localparam int IRQ_DATA = 1;
    // Comparator slots
    localparam int CMP_NUM = 4;
    localparam int CMP_IADDR = 0;
    localparam int CMP_DADDR = 1;
    localparam int CMP_SVAL = 2;
    localparam int CMP_LVAL = 3;
    // Trigger timing: pclk serves as the bus clock
    localparam int PROBE_TRIGGER_OUT_BUS_CYCLES = 2;
    localparam int PCLK_PER_BUS = 1;
    localparam logic [2:0] PROBE_TRIGGER_OUT_LOAD = 3'(PROBE_TRIGGER_OUT_BUS_CYCLES * PCLK_PER_BUS - 1);
    // Processor operating modes
    typedef enum logic [1:0] {
        HBU_KERNEL,
        HBU_SUPER,
        HBU_USER,
        HBU_RSVD
    } hbu_mode_type;
    // Pending late value compare
    typedef enum {
        HBU_LV_IDLE,
        HBU_LV_WAIT
    } hbu_lv_state_type;
endpackage

// [hdl/hbu_cmp_if.sv]
// Carrier between the top and one masked comparator
`timescale 1ns/100ps
interface hbu_cmp_if;
    logic [31:0] ref_val;
    logic [31:0] mask_val;
    logic [31:0] probe_val;
    logic hit;
    modport cmp (input ref_val, input mask_val, input probe_val, output hit);
    modport user (output ref_val, output mask_val, output probe_val, input hit);
endinterface

// [hdl/hbu_match.sv]
// Masked 32-bit equality comparator
`timescale 1ns/100ps
module hbu_match
    import hbu_pkg::*;
(
    hbu_cmp_if.cmp port // Reference, mask, probe and hit
);
    // Set mask bits drop out of the compare
    assign port.hit = (((port.ref_val ^ port.probe_val) & ~port.mask_val) == 32'h00000000); // [RL16]
endmodule

// [bench/hbu_probe_model.sv]
// Probe model that measures trigger pulses
`timescale 1ns/100ps
module hbu_probe_model (
    input logic pclk, // Bus clock
    input logic presetn, // Reset, active low
    input logic probe_trigger_out_in, // Trigger from the unit
    output logic [7:0] last_len, // Length of last pulse
    output logic [7:0] pulse_cnt // Pulses seen
);
    logic [7:0] run_r;
    // Count high cycles, latch length when the pulse ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 8'h00;
            last_len <= 8'h00;
            pulse_cnt <= 8'h00;
        end else if (probe_trigger_out_in) begin
            run_r <= run_r + 8'h01;
        end else if (run_r != 8'h00) begin
            last_len <= run_r;
            pulse_cnt <= pulse_cnt + 8'h01;
            run_r <= 8'h00;
        end
    end
endmodule

// [bench/tb_hw_breakpoint_unit.sv]
// Self-checking bench of the hardware breakpoint unit
`timescale 1ns/100ps
`define CHK(n, e, g) \
    check_count++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("MISMATCH %s exp %h got %h", n, e, g); \
    end
module tb_hw_breakpoint_unit import hbu_pkg::*;;
    localparam logic [31:0] IA = 32'h1 << BIT_IADDR_EN;
    localparam logic [31:0] DR = 32'h1 << BIT_DREAD_EN;
    localparam logic [31:0] DW = 32'h1 << BIT_DWRITE_EN;
    localparam logic [31:0] DV = 32'h1 << BIT_DVAL_EN;
    localparam logic [31:0] IK = 32'h1 << (FLD_IMODE_LO + MODE_K);
    localparam logic [31:0] IX = 32'h1 << (FLD_IMODE_LO + MODE_X);
    localparam logic [31:0] DK = 32'h1 << (FLD_DMODE_LO + MODE_K);
    localparam logic [31:0] IE = 32'h1 << BIT_IEXC;
    localparam logic [31:0] DE = 32'h1 << BIT_DEXC;
    localparam logic [31:0] TE = 32'h1 << BIT_PROBE_EN;
    localparam logic [31:0] IHIT = 32'h1000_004C;
    localparam logic [31:0] DHIT = 32'h2000_0103;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, ifetch_vaddr = 32'h0, dacc_vaddr = 32'h0;
    logic [31:0] dacc_wdata = 32'h0, late_data = 32'h0;
    logic ifetch_valid = 1'b0, dacc_valid = 1'b0, dacc_write = 1'b0, dacc_fpu_store = 1'b0;
    logic late_valid = 1'b0, cpu_exl = 1'b0, cpu_erl = 1'b0;
    logic [1:0] cpu_mode = 2'h0, ien = 2'h0;
    logic [31:0] prdata, rd, ctrl;
    logic pready, pslverr, bp_exc_req, probe_trigger_out, irq, rerr;
    logic [7:0] last_len, pulse_cnt, p0;
    int failures = 0, check_count = 0, cyc = 0;

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    hbu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ifetch_valid(ifetch_valid), .ifetch_vaddr(ifetch_vaddr),
        .dacc_valid(dacc_valid), .dacc_write(dacc_write), .dacc_fpu_store(dacc_fpu_store),
        .dacc_vaddr(dacc_vaddr), .dacc_wdata(dacc_wdata), .late_valid(late_valid),
        .late_data(late_data), .cpu_mode(cpu_mode), .cpu_exl(cpu_exl), .cpu_erl(cpu_erl),
        .bp_exc_req(bp_exc_req), .probe_trigger_out(probe_trigger_out), .irq(irq));

    hbu_probe_model probe (.pclk(pclk), .presetn(presetn), .probe_trigger_out_in(probe_trigger_out),
        .last_len(last_len), .pulse_cnt(pulse_cnt));

    // Verdict and end of run
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            stop_test();
        end
    end

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic [31:0] c);
        ctrl = c;
        apb(1'b1, OFS_CTRL, c);
    endtask

    task automatic fetch(input logic [31:0] a);
        @(posedge pclk);
        ifetch_valid <= 1'b1;
        ifetch_vaddr <= a;
    endtask

    task automatic dacc(input logic w, f, input logic [31:0] a, d);
        @(posedge pclk);
        dacc_valid <= 1'b1;
        dacc_write <= w;
        dacc_fpu_store <= f;
        dacc_vaddr <= a;
        dacc_wdata <= d;
    endtask

    task automatic late(input logic [31:0] d);
        @(posedge pclk);
        late_valid <= 1'b1;
        late_data <= d;
    endtask

    task automatic idle;
        @(posedge pclk);
        ifetch_valid <= 1'b0;
        dacc_valid <= 1'b0;
        late_valid <= 1'b0;
    endtask

    // Close the strobe, judge exception, trigger, irq, status, then clear
    task automatic expect_evt(input logic e, t, input logic [2:0] st);
        logic [1:0] is;
        is = {st[2] | st[1], st[0]};
        p0 = pulse_cnt;
        idle();
        #1;
        `CHK("exc", e, bp_exc_req)
        repeat (4) @(posedge pclk);
        `CHK("probe_trigger_out_pulses", 8'(p0 + 8'(t)), pulse_cnt)
        if (t) begin
            `CHK("probe_trigger_out_len", 8'h02, last_len)
        end
        `CHK("irq", |(is & ien), irq)
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("status", st, rd[2:0])
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        `CHK("irq_stat", is, rd[1:0])
        apb(1'b1, OFS_CTRL, ctrl);
        apb(1'b1, OFS_IRQ_CLR, 32'h3);
        repeat (2) @(posedge pclk);
        `CHK("irq_clr", 1'b0, irq)
    endtask

    task automatic t_regs;
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl_rst", 32'h0, rd)
        apb(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl_wmask", CTRL_WMASK, rd)
        apb(1'b0, 8'h28, 32'h0);
        `CHK("unmapped_err", 2'h3, {rerr, ~|rd})
        apb(1'b1, OFS_IADDR, 32'h1000_0040);
        apb(1'b1, OFS_IADDR_MASK, 32'h0000_000F);
        apb(1'b1, OFS_DADDR, 32'h2000_0100);
        apb(1'b1, OFS_DADDR_MASK, 32'h0000_0003);
        apb(1'b1, OFS_DVAL, 32'hCAFE_0000);
        apb(1'b1, OFS_DVAL_MASK, 32'h0000_00FF);
        apb(1'b0, OFS_IADDR_MASK, 32'h0);
        `CHK("imask_rd", 32'h0000_000F, rd)
        apb(1'b1, OFS_IRQ_EN, 32'h1);
        ien = 2'h1;
        cfg(32'h0);
    endtask

    task automatic t_instr;
        cfg(IA | IK | IE | TE);
        fetch(IHIT);
        expect_evt(1'b1, 1'b1, 3'h1);
        fetch(32'h1000_0050);
        expect_evt(1'b0, 1'b0, 3'h0);
        cpu_mode <= HBU_USER;
        fetch(IHIT);
        expect_evt(1'b0, 1'b0, 3'h0);
        cpu_mode <= HBU_SUPER;
        fetch(IHIT);
        expect_evt(1'b0, 1'b0, 3'h0);
        cpu_mode <= HBU_KERNEL;
        cpu_exl <= 1'b1;
        fetch(IHIT);
        expect_evt(1'b0, 1'b0, 3'h0);
        cfg(IA | IX | IE | TE);
        fetch(IHIT);
        expect_evt(1'b1, 1'b1, 3'h1);
        cpu_exl <= 1'b0;
        cpu_erl <= 1'b1;
        fetch(IHIT);
        expect_evt(1'b0, 1'b1, 3'h1);
        cpu_erl <= 1'b0;
        cfg(IA | IK | TE | DE);
        fetch(IHIT);
        expect_evt(1'b0, 1'b1, 3'h1);
        cfg(IA | IK | IE);
        fetch(IHIT);
        expect_evt(1'b1, 1'b0, 3'h1);
    endtask

    task automatic t_data;
        cfg(DW | DV | DK | DE | TE | IE);
        dacc(1'b1, 1'b0, DHIT, 32'hCAFE_1200);
        expect_evt(1'b0, 1'b0, 3'h0);
        dacc(1'b1, 1'b0, DHIT, 32'hCAFE_0055);
        expect_evt(1'b1, 1'b1, 3'h4);
        dacc(1'b0, 1'b0, DHIT, 32'h0);
        idle();
        late(32'hCAFE_0000);
        expect_evt(1'b0, 1'b0, 3'h0);
        cfg(DW | DK | DE | TE);
        dacc(1'b1, 1'b0, 32'h2000_0104, 32'hCAFE_0000);
        expect_evt(1'b0, 1'b0, 3'h0);
        cfg(DV | DK | DE | TE);
        dacc(1'b1, 1'b0, DHIT, 32'hCAFE_0000);
        expect_evt(1'b0, 1'b0, 3'h0);
    endtask

    task automatic t_late;
        apb(1'b1, OFS_IRQ_EN, 32'h3);
        ien = 2'h3;
        cfg(DR | DV | DK | DE | TE);
        dacc(1'b0, 1'b0, DHIT, 32'h0);
        idle();
        late(32'hCAFF_0000);
        expect_evt(1'b0, 1'b0, 3'h0);
        dacc(1'b0, 1'b0, DHIT, 32'h0);
        idle();
        late(32'hCAFE_00AA);
        expect_evt(1'b1, 1'b1, 3'h2);
        cfg(DW | DV | DK | DE | TE);
        dacc(1'b1, 1'b1, DHIT, 32'h0);
        idle();
        late(32'hCAFE_0001);
        expect_evt(1'b1, 1'b1, 3'h4);
    endtask

    // Reset, then the scenarios
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_instr();
        t_data();
        t_late();
        stop_test();
    end
endmodule
